// File: verilog/bsf_cfg.svh
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH
// bit positions inside the status flags register
`define BSF_FLAG_C 0
`define BSF_FLAG_Z 1
`define BSF_FLAG_N 2
`define BSF_FLAG_V 3
`define BSF_FLAG_S 4
`define BSF_FLAG_H 5
`define BSF_FLAG_T 6
`define BSF_FLAG_I 7
// instruction cost in core cycles
`define BSF_CYC_PLAIN 3'h1
`define BSF_CYC_SKIP_SHORT 3'h2
`define BSF_CYC_SKIP_LONG 3'h3
`define BSF_CYC_BRANCH_TAKEN 3'h2
`define BSF_CYC_REL_JUMP 3'h2
`define BSF_CYC_IND_JUMP 3'h2
`define BSF_CYC_REL_ENTRY 3'h3
`define BSF_CYC_IND_ENTRY 3'h3
`define BSF_CYC_DIR_ENTRY 3'h4
`define BSF_CYC_EXIT 3'h4
// reset values
`define BSF_PC_RST 16'h0000
`define BSF_FLAGS_RST 8'h00
`endif

// File: verilog/bsf_pkg.sv
package bsf_pkg;
  typedef enum logic [4:0] {
    OP_OTHER,
    OP_COMPARE_SKIP_IF_EQUAL,
    OP_COMPARE_REGISTERS,
    OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALFCARRY_SET,
    OP_BRANCH_HALFCARRY_CLEAR,
    OP_BRANCH_TRANSFER_BIT_SET,
    OP_BRANCH_TRANSFER_BIT_CLEAR,
    OP_RELATIVE_JUMP,
    OP_INDIRECT_JUMP,
    OP_RELATIVE_SUBROUTINE_ENTRY,
    OP_INDIRECT_SUBROUTINE_ENTRY,
    OP_DIRECT_SUBROUTINE_ENTRY,
    OP_SUBROUTINE_EXIT,
    OP_INTERRUPT_EXIT
  } bsf_op_t;

  typedef struct packed {
    bsf_op_t op;
    logic [2:0] bitSel;
    logic [11:0] offset;
    logic [7:0] imm;
    logic [15:0] target;
  } bsf_instr_t;

  typedef struct packed {
    logic h;
    logic v;
    logic n;
    logic z;
    logic c;
  } bsf_cmpflags_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic [15:0] addr;
  } bsf_stack_t;

  typedef enum logic {ST_EXEC, ST_HOLD} bsf_state_t;
endpackage

// File: verilog/bsf_compare_unit.sv
`timescale 1ns/1ps
`default_nettype none
module bsf_compare_unit
  import bsf_pkg::*;
(
  // operands
  input wire logic [7:0] lhs,
  input wire logic [7:0] rhs,
  input wire logic useCarry,
  input wire logic carryIn,
  input wire logic zeroIn,
  // flags
  output bsf_cmpflags_t flags
);
  logic [7:0] diff;
  logic borrowIn;

  always_comb
  begin
    borrowIn = useCarry & carryIn;
    diff = 8'(lhs - rhs - {7'h00, borrowIn});
    flags.h = (~lhs[3] & rhs[3]) | (rhs[3] & diff[3]) | (diff[3] & ~lhs[3]);
    flags.v = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);
    flags.n = diff[7];
    // with carry, zero can only stay set so multi-byte compares chain
    flags.z = (diff == 8'h00) & (~useCarry | zeroIn);
    flags.c = (~lhs[7] & rhs[7]) | (rhs[7] & diff[7]) | (diff[7] & ~lhs[7]);
  end
endmodule // bsf_compare_unit
`default_nettype wire

// File: verilog/bsf_flow_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsf_cfg.svh"
module bsf_flow_control
  import bsf_pkg::*;
#(
  parameter int PC_W = 13,
  parameter bit HAS_DIRECT_ENTRY = 1'b1
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // decoded instruction
  input wire logic instrValid,
  input wire bsf_instr_t instr,
  input wire logic nextTwoWord,
  output logic instrReady,
  // operands
  input wire logic [7:0] rdVal,
  input wire logic [7:0] rrVal,
  input wire logic ioBit,
  input wire logic [15:0] zPtr,
  input wire logic [15:0] stackTop,
  input wire logic [7:0] statusFlags,
  // results
  output logic [PC_W-1:0] pcOut,
  output logic [7:0] flagsOut,
  output logic flagsWe,
  output bsf_stack_t stackOp
);
  if (PC_W < 12 || PC_W > 16)
  begin : g_bad_pc_w
    $error("PC_W must lie between 12 and 16");
  end

  bsf_state_t state_ff, nxt_state;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [7:0] flags_ff, nxt_flags;
  logic flagsWe_ff, nxt_flagsWe;
  bsf_stack_t stack_ff, nxt_stack;

  logic accept;
  logic busy;
  logic [PC_W-1:0] pcInc;
  logic [PC_W-1:0] relTarget;
  logic [PC_W-1:0] skipTarget;
  logic [2:0] skipCyc;
  logic condBit;
  logic isBranch;
  logic isCompare;
  logic skipHit;
  logic [7:0] cmpRhs;
  bsf_cmpflags_t cmpFlags;
  logic [2:0] cyc;

  assign busy = (state_ff == ST_HOLD);
  assign instrReady = ~busy;
  assign accept = instrValid & ~busy;
  assign pcInc = PC_W'(pc_ff + PC_W'(1));
  assign relTarget = PC_W'(pc_ff + PC_W'($signed(instr.offset)) + PC_W'(1));
  // skipping a two-word instruction costs one extra fetch
  assign skipTarget = PC_W'(pc_ff + (nextTwoWord ? PC_W'(3) : PC_W'(2)));
  assign skipCyc = nextTwoWord ? `BSF_CYC_SKIP_LONG : `BSF_CYC_SKIP_SHORT;

  assign cmpRhs = (instr.op == OP_COMPARE_IMMEDIATE) ? instr.imm : rrVal;
  // branches sit as one unbroken run inside the opcode enum
  assign isBranch = instr.op inside
    {[OP_BRANCH_FLAG_SET:OP_BRANCH_TRANSFER_BIT_CLEAR]};
  assign isCompare = instr.op inside
    {OP_COMPARE_REGISTERS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE};

  bsf_compare_unit u_bsf_compare_unit
  (
    .lhs(rdVal),
    .rhs(cmpRhs),
    .useCarry(instr.op == OP_COMPARE_WITH_CARRY),
    .carryIn(statusFlags[`BSF_FLAG_C]),
    .zeroIn(statusFlags[`BSF_FLAG_Z]),
    .flags(cmpFlags)
  );

  // branch condition and skip test
  always_comb
  begin
    condBit = 1'b0;
    skipHit = 1'b0;
    unique case (instr.op)
      OP_BRANCH_FLAG_SET: condBit = statusFlags[instr.bitSel];
      OP_BRANCH_FLAG_CLEAR: condBit = ~statusFlags[instr.bitSel];
      OP_BRANCH_EQUAL: condBit = statusFlags[`BSF_FLAG_Z];
      OP_BRANCH_NOT_EQUAL: condBit = ~statusFlags[`BSF_FLAG_Z];
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER: condBit = statusFlags[`BSF_FLAG_C];
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_OR_HIGHER: condBit = ~statusFlags[`BSF_FLAG_C];
      OP_BRANCH_MINUS: condBit = statusFlags[`BSF_FLAG_N];
      OP_BRANCH_PLUS: condBit = ~statusFlags[`BSF_FLAG_N];
      // sign taken from N and V, not the stored S bit
      OP_BRANCH_SIGNED_GE:
        condBit = ~(statusFlags[`BSF_FLAG_N] ^ statusFlags[`BSF_FLAG_V]);
      OP_BRANCH_SIGNED_LT:
        condBit = statusFlags[`BSF_FLAG_N] ^ statusFlags[`BSF_FLAG_V];
      OP_BRANCH_HALFCARRY_SET: condBit = statusFlags[`BSF_FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: condBit = ~statusFlags[`BSF_FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: condBit = statusFlags[`BSF_FLAG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: condBit = ~statusFlags[`BSF_FLAG_T];
      OP_COMPARE_SKIP_IF_EQUAL: skipHit = (rdVal == rrVal);
      OP_SKIP_REG_BIT_CLEAR: skipHit = ~rrVal[instr.bitSel];
      OP_SKIP_REG_BIT_SET: skipHit = rrVal[instr.bitSel];
      OP_SKIP_IO_BIT_CLEAR: skipHit = ~ioBit;
      OP_SKIP_IO_BIT_SET: skipHit = ioBit;
      default: ;
    endcase
  end

  // program counter, stall counter, flags and stack requests
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pc = pc_ff;
    nxt_flags = flags_ff;
    nxt_flagsWe = 1'b0;
    nxt_stack = '0;
    cyc = `BSF_CYC_PLAIN;
    if (busy)
    begin
      // later cycles of a multi-cycle instruction take no new work
      nxt_cnt = 2'(cnt_ff - 2'h1);
      if (cnt_ff == 2'h1)
        nxt_state = ST_EXEC;
    end
    else if (accept)
    begin
      nxt_pc = pcInc;
      nxt_flags = statusFlags;
      if (isBranch && condBit)
      begin
        nxt_pc = relTarget;
        cyc = `BSF_CYC_BRANCH_TAKEN;
      end
      else if (skipHit)
      begin
        nxt_pc = skipTarget;
        cyc = skipCyc;
      end
      else if (isCompare)
      begin
        nxt_flags[`BSF_FLAG_Z] = cmpFlags.z;
        nxt_flags[`BSF_FLAG_N] = cmpFlags.n;
        nxt_flags[`BSF_FLAG_V] = cmpFlags.v;
        nxt_flags[`BSF_FLAG_C] = cmpFlags.c;
        nxt_flags[`BSF_FLAG_H] = cmpFlags.h;
        nxt_flagsWe = 1'b1;
      end
      else
      begin
        unique case (instr.op)
          OP_RELATIVE_JUMP:
          begin
            nxt_pc = relTarget;
            cyc = `BSF_CYC_REL_JUMP;
          end
          OP_INDIRECT_JUMP:
          begin
            nxt_pc = zPtr[PC_W-1:0];
            cyc = `BSF_CYC_IND_JUMP;
          end
          OP_RELATIVE_SUBROUTINE_ENTRY:
          begin
            nxt_stack.push = 1'b1;
            nxt_stack.addr = 16'(pcInc);
            nxt_pc = relTarget;
            cyc = `BSF_CYC_REL_ENTRY;
          end
          OP_INDIRECT_SUBROUTINE_ENTRY:
          begin
            nxt_stack.push = 1'b1;
            nxt_stack.addr = 16'(pcInc);
            nxt_pc = zPtr[PC_W-1:0];
            cyc = `BSF_CYC_IND_ENTRY;
          end
          OP_DIRECT_SUBROUTINE_ENTRY:
            // small-memory variant lacks it and treats it as one-cycle no-op
            if (HAS_DIRECT_ENTRY)
            begin
              nxt_stack.push = 1'b1;
              nxt_stack.addr = 16'(PC_W'(pc_ff + PC_W'(2)));
              nxt_pc = instr.target[PC_W-1:0];
              cyc = `BSF_CYC_DIR_ENTRY;
            end
          OP_SUBROUTINE_EXIT:
          begin
            nxt_stack.pop = 1'b1;
            nxt_pc = stackTop[PC_W-1:0];
            cyc = `BSF_CYC_EXIT;
          end
          OP_INTERRUPT_EXIT:
          begin
            nxt_stack.pop = 1'b1;
            nxt_pc = stackTop[PC_W-1:0];
            nxt_flags[`BSF_FLAG_I] = 1'b1;
            nxt_flagsWe = 1'b1;
            cyc = `BSF_CYC_EXIT;
          end
          default: ;
        endcase
      end
      nxt_cnt = 2'(cyc - 3'h1);
      if (cyc != `BSF_CYC_PLAIN)
        nxt_state = ST_HOLD;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_EXEC;
      cnt_ff <= 2'h0;
      pc_ff <= PC_W'(`BSF_PC_RST);
      flags_ff <= `BSF_FLAGS_RST;
      flagsWe_ff <= 1'b0;
      stack_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pc_ff <= nxt_pc;
      flags_ff <= nxt_flags;
      flagsWe_ff <= nxt_flagsWe;
      stack_ff <= nxt_stack;
    end
  end

  assign pcOut = pc_ff;
  assign flagsOut = flags_ff;
  assign flagsWe = flagsWe_ff;
  assign stackOp = stack_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_hold1;
    busy ##1 !busy;
  endsequence
  sequence s_hold2;
    busy [*2] ##1 !busy;
  endsequence
  sequence s_hold3;
    busy [*3] ##1 !busy;
  endsequence

  property p_skip_eq_long;
    accept && instr.op == OP_COMPARE_SKIP_IF_EQUAL && rdVal == rrVal &&
      nextTwoWord |=> pc_ff == PC_W'($past(pc_ff) + PC_W'(3)) ##0 s_hold2;
  endproperty
  a_skip_eq_long: assert property (p_skip_eq_long)
    else $error("equal skip over long instruction wrong");

  property p_compare_zero;
    accept && instr.op == OP_COMPARE_REGISTERS |=>
      flagsWe && !busy &&
      flagsOut[`BSF_FLAG_Z] == ($past(rdVal) == $past(rrVal));
  endproperty
  a_compare_zero: assert property (p_compare_zero)
    else $error("compare zero flag wrong");

  property p_regbit_clear;
    accept && instr.op == OP_SKIP_REG_BIT_CLEAR && !rrVal[instr.bitSel] &&
      !nextTwoWord |=> pc_ff == PC_W'($past(pc_ff) + PC_W'(2)) ##0 s_hold1;
  endproperty
  a_regbit_clear: assert property (p_regbit_clear)
    else $error("register bit clear skip wrong");

  property p_regbit_set;
    accept && instr.op == OP_SKIP_REG_BIT_SET && !rrVal[instr.bitSel] |=>
      pc_ff == PC_W'($past(pc_ff) + PC_W'(1)) && !busy;
  endproperty
  a_regbit_set: assert property (p_regbit_set)
    else $error("register bit set skip taken wrongly");

  property p_iobit_clear;
    accept && instr.op == OP_SKIP_IO_BIT_CLEAR && ioBit |=>
      pc_ff == PC_W'($past(pc_ff) + PC_W'(1)) && !busy;
  endproperty
  a_iobit_clear: assert property (p_iobit_clear)
    else $error("io bit clear skip taken wrongly");

  property p_iobit_set;
    accept && instr.op == OP_SKIP_IO_BIT_SET && ioBit && nextTwoWord |=>
      pc_ff == PC_W'($past(pc_ff) + PC_W'(3)) ##0 s_hold2;
  endproperty
  a_iobit_set: assert property (p_iobit_set)
    else $error("io bit set skip wrong");

  property p_flag_set_taken;
    accept && instr.op == OP_BRANCH_FLAG_SET && statusFlags[instr.bitSel]
      |=> pc_ff == $past(relTarget) ##0 s_hold1;
  endproperty
  a_flag_set_taken: assert property (p_flag_set_taken)
    else $error("flag set branch not taken");

  property p_signed_lt;
    accept && instr.op == OP_BRANCH_SIGNED_LT &&
      (statusFlags[`BSF_FLAG_N] == statusFlags[`BSF_FLAG_V]) |=>
      pc_ff == PC_W'($past(pc_ff) + PC_W'(1)) && !busy;
  endproperty
  a_signed_lt: assert property (p_signed_lt)
    else $error("signed less-than taken wrongly");

  property p_ind_entry;
    accept && instr.op == OP_INDIRECT_SUBROUTINE_ENTRY |=>
      stackOp.push && pc_ff == $past(zPtr[PC_W-1:0]) &&
      stackOp.addr == 16'($past(pcInc)) ##0 s_hold2;
  endproperty
  a_ind_entry: assert property (p_ind_entry)
    else $error("indirect entry wrong");

  property p_ind_jump;
    accept && instr.op == OP_INDIRECT_JUMP |=>
      pc_ff == $past(zPtr[PC_W-1:0]) && !stackOp.push ##0 s_hold1;
  endproperty
  a_ind_jump: assert property (p_ind_jump)
    else $error("indirect jump wrong");

  property p_rel_entry;
    accept && instr.op == OP_RELATIVE_SUBROUTINE_ENTRY |=>
      stackOp.push && pc_ff == $past(relTarget) ##0 s_hold2;
  endproperty
  a_rel_entry: assert property (p_rel_entry)
    else $error("relative entry wrong");

  property p_int_exit;
    accept && instr.op == OP_INTERRUPT_EXIT |=>
      stackOp.pop && flagsWe && flagsOut[`BSF_FLAG_I] &&
      pc_ff == $past(stackTop[PC_W-1:0]) ##0 s_hold3;
  endproperty
  a_int_exit: assert property (p_int_exit)
    else $error("interrupt exit wrong");
endmodule // bsf_flow_control
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsf_cfg.svh"
module tb_top;
  import bsf_pkg::*;
  localparam int PW = 13;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instrValid = 1'b0;
  bsf_instr_t instr = '0;
  logic nextTwoWord = 1'b0;
  logic [7:0] rdVal = 8'h00;
  logic [7:0] rrVal = 8'h00;
  logic ioBit = 1'b0;
  logic [15:0] zPtr = 16'h0000;
  logic [15:0] stackTop = 16'h0000;
  logic [7:0] statusFlags = 8'h00;
  logic instrReady;
  logic [PW-1:0] pcOut;
  logic [7:0] flagsOut;
  logic flagsWe;
  bsf_stack_t stackOp;
  logic [PW-1:0] pcExp;
  logic [7:0] fSeen;
  logic weSeen;
  bsf_stack_t stSeen;
  int num_errors = 0;
  int checks_done = 0;

  bsf_flow_control #(.PC_W(PW), .HAS_DIRECT_ENTRY(1'b1)) u_bsf_flow_control (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .instrValid(instrValid),
    .instr(instr), .nextTwoWord(nextTwoWord), .instrReady(instrReady),
    .rdVal(rdVal), .rrVal(rrVal), .ioBit(ioBit), .zPtr(zPtr),
    .stackTop(stackTop), .statusFlags(statusFlags), .pcOut(pcOut),
    .flagsOut(flagsOut), .flagsWe(flagsWe), .stackOp(stackOp));

  always #25 sys_clk = ~sys_clk;

  task print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one instruction through the accept handshake; result pc and cost judged
  task exec(input bsf_op_t op, input logic [2:0] bs, input logic [11:0] off,
    input logic [15:0] tg, input logic [7:0] rd, input logic [7:0] rr,
    input logic [7:0] fl, input logic io, input logic ntw,
    input logic [PW-1:0] ePc, input int eCyc);
    int cyc;
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instr <= '{op: op, bitSel: bs, offset: off, imm: rr, target: tg};
    // register operand differs from immediate so a wrong pick shows
    rrVal <= (op == OP_COMPARE_IMMEDIATE) ? ~rr : rr;
    rdVal <= rd;
    statusFlags <= fl;
    ioBit <= io;
    nextTwoWord <= ntw;
    zPtr <= tg;
    stackTop <= tg;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    #1;
    fSeen = flagsOut;
    weSeen = flagsWe;
    stSeen = stackOp;
    check(pcOut, ePc);
    pcExp = ePc;
    cyc = 1;
    while (instrReady !== 1'b1 && cyc < 8)
    begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end
    check(cyc, eCyc);
    if (instrReady !== 1'b1)
      print_verdict();
  endtask

  function automatic logic [PW-1:0] rel(input logic [11:0] off);
    return pcExp + PW'($signed(off)) + 1'b1;
  endfunction

  function automatic logic [7:0] cmpExp(input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] f, input logic uc);
    logic [8:0] d;
    logic [7:0] r;
    d = {1'b0, a} - {1'b0, b} - {8'h00, uc & f[`BSF_FLAG_C]};
    r = d[7:0];
    cmpExp = f;
    cmpExp[`BSF_FLAG_C] = d[8];
    // with carry, zero can only be kept, never set
    cmpExp[`BSF_FLAG_Z] = (r == 8'h00) && (!uc || f[`BSF_FLAG_Z]);
    cmpExp[`BSF_FLAG_N] = r[7];
    cmpExp[`BSF_FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    cmpExp[`BSF_FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  endfunction

  function automatic logic brTaken(input bsf_op_t op, input logic [7:0] f,
    input logic [2:0] s);
    case (op)
      OP_BRANCH_FLAG_SET: return f[s];
      OP_BRANCH_FLAG_CLEAR: return !f[s];
      OP_BRANCH_EQUAL: return f[`BSF_FLAG_Z];
      OP_BRANCH_NOT_EQUAL: return !f[`BSF_FLAG_Z];
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: return f[`BSF_FLAG_C];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGHER: return !f[`BSF_FLAG_C];
      OP_BRANCH_MINUS: return f[`BSF_FLAG_N];
      OP_BRANCH_PLUS: return !f[`BSF_FLAG_N];
      OP_BRANCH_SIGNED_GE: return !(f[`BSF_FLAG_N] ^ f[`BSF_FLAG_V]);
      OP_BRANCH_SIGNED_LT: return f[`BSF_FLAG_N] ^ f[`BSF_FLAG_V];
      OP_BRANCH_HALFCARRY_SET: return f[`BSF_FLAG_H];
      OP_BRANCH_HALFCARRY_CLEAR: return !f[`BSF_FLAG_H];
      OP_BRANCH_TRANSFER_BIT_SET: return f[`BSF_FLAG_T];
      default: return !f[`BSF_FLAG_T];
    endcase
  endfunction

  task t_reset(input int n);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    check(pcOut, '0);
    check({flagsOut, flagsWe, stackOp, instrReady}, 28'h0000001);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    pcExp = '0;
  endtask

  task automatic t_compare;
    bsf_op_t cOp [6] = '{OP_COMPARE_REGISTERS, OP_COMPARE_REGISTERS,
      OP_COMPARE_WITH_CARRY, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
      OP_COMPARE_IMMEDIATE};
    logic [7:0] cA [6] = '{8'h10, 8'h00, 8'h05, 8'h05, 8'h80, 8'h3c};
    logic [7:0] cB [6] = '{8'h10, 8'h01, 8'h04, 8'h04, 8'h01, 8'h3c};
    logic [7:0] cF [6] = '{8'hd0, 8'h52, 8'h01, 8'h03, 8'h00, 8'hff};
    for (int k = 0; k < 6; k++)
    begin
      exec(cOp[k], '0, '0, '0, cA[k], cB[k], cF[k], 1'b0, 1'b0,
        PW'(pcExp + PW'(1)), 1);
      check({weSeen, fSeen}, {1'b1, cmpExp(cA[k], cB[k], cF[k],
        cOp[k] == OP_COMPARE_WITH_CARRY)});
    end
  endtask

  task automatic t_skip;
    bsf_op_t sOps [5] = '{OP_COMPARE_SKIP_IF_EQUAL, OP_SKIP_REG_BIT_CLEAR,
      OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
    bsf_op_t op;
    logic sk;
    logic ntw;
    logic [2:0] bs;
    logic [7:0] m;
    logic [7:0] rd;
    logic [7:0] rr;
    int n;
    for (int k = 0; k < 20; k++)
    begin
      op = sOps[k / 4];
      sk = k[0];
      ntw = k[1];
      bs = 3'(k * 3);
      m = 8'h01 << bs;
      rd = (op == OP_SKIP_REG_BIT_SET) == sk ? m : ~m;
      rr = rd;
      if (op == OP_COMPARE_SKIP_IF_EQUAL)
      begin
        rd = 8'h5a;
        rr = sk ? 8'h5a : 8'h5b;
      end
      n = sk ? (ntw ? 3 : 2) : 1;
      exec(op, bs, '0, '0, rd, rr, 8'h00, (op == OP_SKIP_IO_BIT_SET) == sk,
        ntw, pcExp + n, n);
    end
  endtask

  task automatic t_branch;
    logic [7:0] fl [6] = '{8'h00, 8'hff, 8'h08, 8'h04, 8'h2a, 8'h55};
    logic [11:0] off [4] = '{12'h7ff, 12'h800, 12'hffe, 12'h003};
    bsf_op_t op;
    logic tk;
    logic [2:0] bs;
    for (int o = OP_BRANCH_FLAG_SET; o <= OP_BRANCH_TRANSFER_BIT_CLEAR; o++)
      for (int j = 0; j < 6; j++)
      begin
        op = bsf_op_t'(o);
        bs = 3'(o + j);
        tk = brTaken(op, fl[j], bs);
        exec(op, bs, off[j % 4], '0, '0, '0, fl[j], 1'b0, 1'b0,
          tk ? rel(off[j % 4]) : pcExp + 1, tk ? 2 : 1);
        check({weSeen, stSeen.push, stSeen.pop}, 3'h0);
      end
  endtask

  // an offer made while a jump stalls must be ignored, not queued
  task automatic t_refuse;
    @(posedge sys_clk);
    instrValid <= 1'b1;
    instr <= '{op: OP_RELATIVE_JUMP, bitSel: 3'h0, offset: 12'h004,
      imm: 8'h00, target: 16'h0000};
    @(posedge sys_clk);
    instr.op <= OP_INDIRECT_JUMP;
    zPtr <= 16'h1555;
    #1;
    check(instrReady, 1'b0);
    @(posedge sys_clk);
    instrValid <= 1'b0;
    #1;
    check({instrReady, pcOut}, {1'b1, PW'(pcExp + PW'(5))});
    pcExp = PW'(pcExp + PW'(5));
  endtask

  task automatic t_jump;
    logic [PW-1:0] p;
    exec(OP_RELATIVE_JUMP, '0, 12'hfff, '0, '0, '0, 8'h00, 1'b0, 1'b0, pcExp, 2);
    exec(OP_INDIRECT_JUMP, '0, '0, 16'h0a5c, '0, '0, 8'h00, 1'b0, 1'b0, 13'h0a5c, 2);
    check({stSeen.push, stSeen.pop}, 2'h0);
    p = pcExp;
    exec(OP_RELATIVE_SUBROUTINE_ENTRY, '0, 12'h010, '0, '0, '0, 8'h00, 1'b0, 1'b0, p + 13'h0011, 3);
    check({stSeen.push, stSeen.pop, stSeen.addr}, {2'h2, 16'(p) + 16'h0001});
    p = pcExp;
    exec(OP_INDIRECT_SUBROUTINE_ENTRY, '0, '0, 16'h1e40, '0, '0, 8'h00, 1'b0, 1'b0, 13'h1e40, 3);
    check({stSeen.push, stSeen.pop, stSeen.addr}, {2'h2, 16'(p) + 16'h0001});
    p = pcExp;
    exec(OP_DIRECT_SUBROUTINE_ENTRY, '0, '0, 16'h0123, '0, '0, 8'h00, 1'b0, 1'b0, 13'h0123, 4);
    check({stSeen.push, stSeen.pop, stSeen.addr}, {2'h2, 16'(p) + 16'h0002});
    exec(OP_SUBROUTINE_EXIT, '0, '0, 16'h0456, '0, '0, 8'h00, 1'b0, 1'b0, 13'h0456, 4);
    check({stSeen.push, stSeen.pop, weSeen}, 3'h2);
    exec(OP_INTERRUPT_EXIT, '0, '0, 16'h0789, '0, '0, 8'h21, 1'b0, 1'b0, 13'h0789, 4);
    check({stSeen.pop, weSeen, fSeen}, {2'h3, 8'ha1});
  endtask

  initial
  begin
    t_reset(16);
    t_compare();
    t_skip();
    t_branch();
    t_refuse();
    t_jump();
    // second reset in mid-run, pc far from zero
    t_reset(2);
    t_jump();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
